// *** shared/tec_map.svh ***
// register offsets, field positions and reset values of the timer/event counter
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH
`define TEC_OFF_CNT   8'h00
`define TEC_OFF_CCA   8'h04
`define TEC_OFF_CCB   8'h08
`define TEC_OFF_MCR   8'h0c
`define TEC_OFF_PRM   8'h10
`define TEC_OFF_CRC   8'h14
`define TEC_OVF_BIT   0
`define TEC_RUN_LSB   2
`define TEC_CKS_LSB   0
`define TEC_ESA_LSB   4
`define TEC_ESB_LSB   6
`define TEC_CAPA_BIT  0
`define TEC_CAPB_BIT  1
`define TEC_OSEN_BIT  2
`define TEC_OSPT_BIT  6
`define TEC_OSBSY_BIT 7
`define TEC_PRM_RST   8'h00
`define TEC_CRC_RST   3'h0
`endif

// *** shared/tec_pkg.sv ***
// types shared by the timer/event counter modules
package tec_pkg;
  typedef enum logic [1:0] {RUN_STOP, RUN_FREE, RUN_EDGE_CLR, RUN_MATCH_CLR} tec_run_t;
  typedef enum logic [1:0] {ES_FALL, ES_RISE, ES_NONE, ES_BOTH} tec_es_t;
  typedef enum logic [1:0] {CKS_DIV1, CKS_DIV2, CKS_DIV4, CKS_EVENT} tec_cks_t;
  typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_HIGH} tec_os_t;
endpackage

// *** rtl/tec_edge_det.sv ***
// pin synchroniser and valid-edge detector
module tec_edge_det
  import tec_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rstn_i,
  input  wire logic    pin_i,
  input  wire logic    en_i,
  input  wire tec_es_t sel_i,
  output logic         edge_o,
  output logic         level_o
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic seen_r;
  logic rise;
  logic fall;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // prev stays low until first enable, so a high pin then reads as a rise;
  // afterwards it tracks the pin even when stopped, so re-enable sees none
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      seen_r <= seen_r | en_i;
      if (seen_r | en_i)
      begin
        prev_r <= sync2_r;
      end
    end
  end

  assign rise    = sync2_r & ~prev_r;
  assign fall    = ~sync2_r & prev_r;
  assign level_o = sync2_r;

  always_comb
  begin
    case (sel_i)
      ES_FALL: edge_o = en_i & fall;
      ES_RISE: edge_o = en_i & rise;
      ES_BOTH: edge_o = en_i & (rise | fall);
      default: edge_o = 1'b0;
    endcase
  end
endmodule

// *** rtl/tec_top.sv ***
// sixteen-bit timer/event counter with two capture/compare registers, APB slave
// Function
// - counter start is not aligned to the count clock; first match may shift one clock.
// - in clear-on-match mode, a zero compare A holds the counter at zero; no one-pulse count.
// - trigger A valid edge comes from prescaler mode bits five and four.
// - further external triggers are ignored while a one-shot pulse is active.
// - in soft one-shot mode, trigger A edges still clear and start a pulse.
// - overflow flag sets when counter wraps all ones to zero.
// - while running, software clear of overflow before counter reaches one has no effect; stopping lifts the block.
// - capture wins over a coinciding write; a coinciding read returns the pre-capture value.
// - reading the counter never captures it into compare B.
// - while stopped, trigger A and capture B inputs are ignored.
// - nonzero run mode starts counting; zero run mode stops the counter.
//
// Chosen here: the APB register port and the register addresses.
`include "tec_map.svh"
module tec_top
  import tec_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic        TRIGGER_INPUT_A_I,
  input  wire logic        CAPTURE_INPUT_B_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             MATCH_IRQ_A_O,
  output logic             MATCH_IRQ_B_O,
  output logic             PULSE_O
);
  logic [CNT_W-1:0] up_counter_r;
  logic [CNT_W-1:0] compare_capture_reg_a_r;
  logic [CNT_W-1:0] compare_capture_reg_b_r;
  tec_run_t         run_r;
  logic             overflow_flag_r;
  logic             ovf_hold_r;
  logic [7:0]       prescaler_mode_reg_r;
  logic [2:0]       crc_r;
  logic [1:0]       div_r;
  tec_os_t          os_st_r;
  tec_os_t          os_st_nxt;
  logic             pready_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic             irq_a_r;
  logic             irq_b_r;
  logic             pulse_r;
  logic [31:0]      rd_nxt;
  logic             mapped;
  logic             acc;
  logic             wr_en;
  logic             running;
  logic             tick;
  logic             ta_edge;
  logic             ta_level;
  logic             cb_edge;
  logic             ta_trig;
  logic             soft_trig;
  logic             os_trig;
  logic             edge_clr;
  logic             clr_any;
  logic             wrap;
  logic             ma;
  logic             mb;
  logic             cap_a;
  logic             cap_b;
  logic             wr_ccb;
  tec_cks_t         cks;
  tec_es_t          es_a;
  tec_es_t          es_b;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);

  assign cks     = tec_cks_t'(prescaler_mode_reg_r[`TEC_CKS_LSB +: 2]);
  assign es_a    = tec_es_t'(prescaler_mode_reg_r[`TEC_ESA_LSB +: 2]);
  assign es_b    = tec_es_t'(prescaler_mode_reg_r[`TEC_ESB_LSB +: 2]);
  assign running = (run_r != RUN_STOP);

  // ---------------- APB slave: one wait state, then ready
  assign acc   = PSEL_I & PENABLE_I;
  assign wr_en = acc & pready_r & PWRITE_I;

  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (PADDR_I)
      `TEC_OFF_CNT: rd_nxt[CNT_W-1:0] = up_counter_r;
      `TEC_OFF_CCA: rd_nxt[CNT_W-1:0] = compare_capture_reg_a_r;
      `TEC_OFF_CCB: rd_nxt[CNT_W-1:0] = compare_capture_reg_b_r;
      `TEC_OFF_MCR:
      begin
        rd_nxt[`TEC_RUN_LSB +: 2] = run_r;
        rd_nxt[`TEC_OVF_BIT]      = overflow_flag_r;
      end
      `TEC_OFF_PRM: rd_nxt[7:0] = prescaler_mode_reg_r;
      `TEC_OFF_CRC:
      begin
        rd_nxt[2:0]            = crc_r;
        rd_nxt[`TEC_OSBSY_BIT] = (os_st_r != OS_IDLE);
      end
      default: mapped = 1'b0;
    endcase
  end

  // read data is sampled one cycle before ready; a capture in that cycle
  // is not reflected, so the value seen is stale
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= acc & ~pready_r;
      if (acc & ~pready_r)
      begin
        prdata_r  <= PWRITE_I ? 32'h0000_0000 : rd_nxt;
        pslverr_r <= ~mapped;
      end
      else if (!acc)
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ---------------- control registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      run_r                <= RUN_STOP;
      prescaler_mode_reg_r <= `TEC_PRM_RST;
      crc_r                <= `TEC_CRC_RST;
    end
    else if (wr_en)
    begin
      case (PADDR_I)
        `TEC_OFF_MCR: run_r <= tec_run_t'(PWDATA_I[`TEC_RUN_LSB +: 2]);
        // edge select is used live; software stops first
        `TEC_OFF_PRM: prescaler_mode_reg_r <= PWDATA_I[7:0];
        `TEC_OFF_CRC: crc_r <= PWDATA_I[2:0];
        default: ;
      endcase
    end
  end

  // ---------------- pin inputs, gated while stopped
  tec_edge_det u_det_a (
    .clk_i   (CLOCK_I),
    .rstn_i  (RESETN_I),
    .pin_i   (TRIGGER_INPUT_A_I),
    .en_i    (running),
    .sel_i   (es_a),
    .edge_o  (ta_edge),
    .level_o (ta_level)
  );

  tec_edge_det u_det_b (
    .clk_i   (CLOCK_I),
    .rstn_i  (RESETN_I),
    .pin_i   (CAPTURE_INPUT_B_I),
    .en_i    (running),
    .sel_i   (es_b),
    .edge_o  (cb_edge),
    .level_o ()
  );

  // ---------------- count clock; divider runs from reset, never on start
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      div_r <= 2'h0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
    end
  end

  always_comb
  begin
    case (cks)
      CKS_DIV1: tick = running;
      CKS_DIV2: tick = running & div_r[0];
      CKS_DIV4: tick = running & (div_r == 2'h3);
      CKS_EVENT: tick = ta_edge;
      default: tick = 1'b0;
    endcase
  end

  // an edge used as count clock cannot also trigger or capture
  assign ta_trig   = ta_edge & (cks != CKS_EVENT);
  assign soft_trig = wr_en & (PADDR_I == `TEC_OFF_CRC) & PWDATA_I[`TEC_OSPT_BIT];
  // external edge stays live in soft mode; idle gate drops extra triggers
  assign os_trig   = running & crc_r[`TEC_OSEN_BIT] & (os_st_r == OS_IDLE)
                     & (soft_trig | ta_trig);
  assign edge_clr  = (run_r == RUN_EDGE_CLR) & ta_trig
                     & ~(crc_r[`TEC_OSEN_BIT] & (os_st_r != OS_IDLE));
  assign clr_any   = os_trig | edge_clr;
  assign wrap      = tick & ~clr_any & (up_counter_r == {CNT_W{1'b1}});

  // ---------------- counter
  // a zero compare A in clear-on-match mode pins the count at zero
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      up_counter_r <= '0;
    end
    else if (!running)
    begin
      up_counter_r <= '0;
    end
    else if (clr_any)
    begin
      up_counter_r <= '0;
    end
    else if (tick)
    begin
      if ((run_r == RUN_MATCH_CLR) && (up_counter_r == compare_capture_reg_a_r))
      begin
        up_counter_r <= '0;
      end
      else
      begin
        up_counter_r <= up_counter_r + CNT_W'(1);
      end
    end
  end

  sequence free_step_s;
    (run_r == RUN_FREE) && tick && !clr_any;
  endsequence
  count_step_a: assert property (free_step_s |=> up_counter_r == $past(up_counter_r) + CNT_W'(1))
    else $error("counter did not advance on count clock");
  stop_clear_a: assert property (run_r == RUN_STOP |=> up_counter_r == '0)
    else $error("stopped counter not zero");
  zero_cmp_a: assert property ((run_r == RUN_MATCH_CLR) && compare_capture_reg_a_r == '0
                              && up_counter_r == '0 && tick && !clr_any
                              |=> up_counter_r == '0)
    else $error("zero compare did not hold counter");

  // ---------------- overflow flag; set beats clear, clear blocked until count one or until stopped
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      overflow_flag_r <= 1'b0;
      ovf_hold_r      <= 1'b0;
    end
    else
    begin
      if (wrap)
      begin
        overflow_flag_r <= 1'b1;
        ovf_hold_r      <= 1'b1;
      end
      else
      begin
        if (tick | ~running)
        begin
          ovf_hold_r <= 1'b0;
        end
        if (wr_en && PADDR_I == `TEC_OFF_MCR && !PWDATA_I[`TEC_OVF_BIT] && !ovf_hold_r)
        begin
          overflow_flag_r <= 1'b0;
        end
      end
    end
  end

  sequence wrap_s;
    tick && !clr_any && up_counter_r == {CNT_W{1'b1}};
  endsequence
  ovf_set_a: assert property (wrap_s |=> overflow_flag_r && up_counter_r == '0)
    else $error("overflow not flagged on wrap");
  ovf_keep_a: assert property (overflow_flag_r && ovf_hold_r |=> overflow_flag_r)
    else $error("overflow cleared before count one");

  // ---------------- compare matches and capture
  assign ma     = tick & ~clr_any & ~crc_r[`TEC_CAPA_BIT]
                  & (up_counter_r == compare_capture_reg_a_r);
  assign mb     = tick & ~clr_any & ~crc_r[`TEC_CAPB_BIT]
                  & (up_counter_r == compare_capture_reg_b_r);
  assign cap_a  = crc_r[`TEC_CAPA_BIT] & cb_edge;
  assign cap_b  = crc_r[`TEC_CAPB_BIT] & ta_trig;
  assign wr_ccb = wr_en & (PADDR_I == `TEC_OFF_CCB);

  // capture beats a software write in the same cycle
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      compare_capture_reg_a_r <= '0;
      compare_capture_reg_b_r <= '0;
    end
    else
    begin
      if (cap_a)
      begin
        compare_capture_reg_a_r <= up_counter_r;
      end
      else if (wr_en && PADDR_I == `TEC_OFF_CCA)
      begin
        compare_capture_reg_a_r <= PWDATA_I[CNT_W-1:0];
      end
      if (cap_b)
      begin
        compare_capture_reg_b_r <= up_counter_r;
      end
      else if (wr_ccb)
      begin
        compare_capture_reg_b_r <= PWDATA_I[CNT_W-1:0];
      end
    end
  end

  cap_b_prio_a: assert property (cap_b |=> compare_capture_reg_b_r == $past(up_counter_r))
    else $error("capture into B lost");
  ccb_hold_a: assert property (!cap_b && !wr_ccb |=> $stable(compare_capture_reg_b_r))
    else $error("B changed without capture or write");
  stop_ignore_a: assert property (!running |-> !ta_edge && !cb_edge)
    else $error("pin edge seen while stopped");
  edge_none_a: assert property (es_a == ES_NONE |-> !ta_edge)
    else $error("edge seen with no edge selected");
  edge_rise_a: assert property (es_a == ES_RISE && ta_edge |-> ta_level)
    else $error("rising select gave falling edge");

  // ---------------- one-shot pulse
  always_comb
  begin
    os_st_nxt = os_st_r;
    case (os_st_r)
      OS_IDLE:
      begin
        if (os_trig)
        begin
          os_st_nxt = OS_WAIT;
        end
      end
      OS_WAIT:
      begin
        if (ma)
        begin
          os_st_nxt = OS_IDLE;
        end
        else if (mb)
        begin
          os_st_nxt = OS_HIGH;
        end
      end
      OS_HIGH:
      begin
        if (ma)
        begin
          os_st_nxt = OS_IDLE;
        end
      end
      default: os_st_nxt = OS_IDLE;
    endcase
    if (!running || !crc_r[`TEC_OSEN_BIT])
    begin
      os_st_nxt = OS_IDLE;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      os_st_r <= OS_IDLE;
      pulse_r <= 1'b0;
    end
    else
    begin
      os_st_r <= os_st_nxt;
      pulse_r <= (os_st_nxt == OS_HIGH);
    end
  end

  os_restart_a: assert property (ta_trig && running && crc_r[`TEC_OSEN_BIT]
                                 && os_st_r == OS_IDLE
                                 |=> up_counter_r == '0 && os_st_r == OS_WAIT)
    else $error("trigger A did not restart one-shot");
  os_ignore_a: assert property ((run_r == RUN_FREE) && crc_r[`TEC_OSEN_BIT]
                                && os_st_r != OS_IDLE && ta_trig && tick
                                |=> up_counter_r == $past(up_counter_r) + CNT_W'(1))
    else $error("trigger during pulse disturbed counter");

  // ---------------- match pulses
  always_ff @(posedge CLOCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end
    else
    begin
      irq_a_r <= ma;
      irq_b_r <= mb;
    end
  end

  irq_match_a: assert property (MATCH_IRQ_A_O == $past(ma) && MATCH_IRQ_B_O == $past(mb))
    else $error("match pulse not one cycle after match");

  assign PRDATA_O      = prdata_r;
  assign PREADY_O      = pready_r;
  assign PSLVERR_O     = pslverr_r;
  assign MATCH_IRQ_A_O = irq_a_r;
  assign MATCH_IRQ_B_O = irq_b_r;
  assign PULSE_O       = pulse_r;
endmodule

// *** tb/tec_pin_model.sv ***
// model of the pins driving trigger input A and capture input B
module tec_pin_model (
  input  wire logic clk_i,
  output logic      trig_a_o,
  output logic      cap_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    trig_a_o = 1'b0;
    cap_b_o  = 1'b0;
  end

  // levels held four clocks, beyond what the synchroniser needs
  task automatic set_a(input logic lvl);
    @(posedge clk_i);
    trig_a_o <= lvl;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic pulse_b();
    @(posedge clk_i);
    cap_b_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cap_b_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench of the timer/event counter
`include "tec_map.svh"
module tb;
  import tec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_a;
  logic        irq_b;
  logic        pulse;
  logic        trig_a;
  logic        cap_b;
  int          num_errors;
  int          comparisons;

  tec_top u_dut (
    .CLOCK_I           (clk),
    .RESETN_I          (rstn),
    .PSEL_I            (psel),
    .PENABLE_I         (penable),
    .PWRITE_I          (pwrite),
    .PADDR_I           (paddr),
    .PWDATA_I          (pwdata),
    .TRIGGER_INPUT_A_I (trig_a),
    .CAPTURE_INPUT_B_I (cap_b),
    .PRDATA_O          (prdata),
    .PREADY_O          (pready),
    .PSLVERR_O         (pslverr),
    .MATCH_IRQ_A_O     (irq_a),
    .MATCH_IRQ_B_O     (irq_b),
    .PULSE_O           (pulse)
  );

  tec_pin_model u_pins (
    .clk_i    (clk),
    .trig_a_o (trig_a),
    .cap_b_o  (cap_b)
  );

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    num_errors++;
    $display("ERROR %s expected event seen none", name);
    stop_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      timeout("apb ready");
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // sel 0 waits for match A, sel 1 for the one-shot output
  task automatic wait_sig(input int sel, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? irq_a : pulse) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
      timeout("wait for event");
  endtask

  task automatic s_reset();
    logic [31:0] q;
    logic        e;
    rd(`TEC_OFF_PRM, q);
    check("prescaler reset", 32'h0, q);
    rd(`TEC_OFF_MCR, q);
    check("mode reset", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
  endtask

  task automatic s_run();
    logic [31:0] a;
    logic [31:0] b;
    wr(`TEC_OFF_CRC, 32'h2);
    u_pins.set_a(1'b1);
    u_pins.set_a(1'b0);
    rd(`TEC_OFF_CNT, a);
    check("stopped count", 32'h0, a);
    rd(`TEC_OFF_CCB, a);
    check("stopped capture", 32'h0, a);
    wr(`TEC_OFF_MCR, 32'h4);
    rd(`TEC_OFF_CNT, a);
    rd(`TEC_OFF_CNT, b);
    check("counting", 32'h1, b > a);
    rd(`TEC_OFF_CCB, a);
    check("read no capture", 32'h0, a);
    wr(`TEC_OFF_CRC, 32'h0);
    // reads are four clocks apart, so a /4 count clock adds exactly one
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_PRM, 32'h2);
    wr(`TEC_OFF_MCR, 32'h4);
    rd(`TEC_OFF_CNT, a);
    rd(`TEC_OFF_CNT, b);
    check("divide by four", 32'h1, b - a);
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_PRM, 32'h0);
  endtask

  task automatic s_capture();
    logic [31:0] a;
    logic [31:0] b;
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_CCA, 32'h0);
    wr(`TEC_OFF_CCB, 32'h0);
    wr(`TEC_OFF_PRM, 32'h50);
    wr(`TEC_OFF_CRC, 32'h3);
    u_pins.set_a(1'b0);
    u_pins.pulse_b();
    rd(`TEC_OFF_CCA, a);
    check("stopped capture a", 32'h0, a);
    wr(`TEC_OFF_MCR, 32'h4);
    u_pins.pulse_b();
    rd(`TEC_OFF_CCA, a);
    check("capture a taken", 32'h1, a > 0 && a < 8);
    u_pins.set_a(1'b1);
    rd(`TEC_OFF_CCB, b);
    check("capture b taken", 32'h1, b > a && b < 32);
    wr(`TEC_OFF_CRC, 32'h0);
  endtask

  task automatic s_match();
    int n;
    int nb;
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_CCA, 32'h10);
    wr(`TEC_OFF_CCB, 32'h8);
    wr(`TEC_OFF_MCR, 32'hc);
    wait_sig(0, 100, n);
    nb = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (irq_b === 1'b1)
        nb++;
    end
    while (irq_a !== 1'b1 && n < 100);
    check("match period", 32'd17, n);
    check("match b count", 32'd1, nb);
  endtask

  task automatic s_edge();
    logic [31:0] q;
    tec_es_t     es;
    for (int i = 0; i < 4; i++)
    begin
      es = tec_es_t'(i);
      wr(`TEC_OFF_MCR, 32'h0);
      wr(`TEC_OFF_PRM, 32'(i) << `TEC_ESA_LSB);
      wr(`TEC_OFF_MCR, 32'h8);
      repeat (20) @(posedge clk);
      u_pins.set_a(1'b1);
      rd(`TEC_OFF_CNT, q);
      check("rise clears", (es == ES_RISE || es == ES_BOTH), q < 16);
      repeat (20) @(posedge clk);
      u_pins.set_a(1'b0);
      rd(`TEC_OFF_CNT, q);
      check("fall clears", (es == ES_FALL || es == ES_BOTH), q < 16);
    end
  endtask

  task automatic s_oneshot();
    int n;
    int w;
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_PRM, 32'h10);
    wr(`TEC_OFF_CCA, 32'h40);
    wr(`TEC_OFF_CCB, 32'h10);
    wr(`TEC_OFF_CRC, 32'h4);
    wr(`TEC_OFF_MCR, 32'h4);
    wr(`TEC_OFF_CRC, 32'h44);
    wait_sig(1, 200, n);
    // a trigger edge inside the pulse would stretch it if honoured
    u_pins.set_a(1'b1);
    w = 5;
    while (pulse === 1'b1 && w < 200)
    begin
      @(posedge clk);
      w++;
    end
    check("pulse width", 32'd48, w);
    wait_sig(0, 100, n);
    u_pins.set_a(1'b0);
    u_pins.set_a(1'b1);
    wait_sig(1, 100, n);
    check("pin starts pulse", 32'h1, n < 100);
    wait_sig(0, 100, n);
  endtask

  task automatic s_overflow();
    logic [31:0] q;
    int          n;
    wr(`TEC_OFF_MCR, 32'h0);
    wr(`TEC_OFF_CRC, 32'h0);
    wr(`TEC_OFF_CCA, 32'hffff);
    wr(`TEC_OFF_MCR, 32'h4);
    wait_sig(0, 70000, n);
    repeat (4) @(posedge clk);
    rd(`TEC_OFF_MCR, q);
    check("overflow set", 32'h1, q[`TEC_OVF_BIT]);
    wr(`TEC_OFF_MCR, 32'h4);
    rd(`TEC_OFF_MCR, q);
    check("overflow cleared", 32'h0, q[`TEC_OVF_BIT]);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    num_errors  = 0;
    comparisons = 0;
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_reset();
    s_run();
    s_match();
    s_edge();
    s_oneshot();
    s_capture();
    s_overflow();
    stop_test();
  end
endmodule
